/* File: dv/stack_mem_model.sv */
`timescale 1ns/1ps
// stack ram beside the core; records strobes
module stack_mem_model
(
	input wire logic i_ref_clk, // cpu clock
	input wire logic i_we, // write strobe
	input wire logic i_re, // read strobe
	input wire logic [15:0] i_addr, // byte address
	input wire logic [7:0] i_wdata, // write data
	input wire logic [2:0] i_sel, // context index
	output int o_writes, // writes seen
	output int o_reads, // reads seen
	output logic [2:0] o_first_sel // first read index
);
	logic [7:0] mem [256]; // one page, high byte fixed
	initial
	begin
		o_writes = 0;
		o_reads = 0;
		o_first_sel = 3'h0;
	end
	// capture bytes on the strobe cycle
	always @(posedge i_ref_clk)
	begin
		if (i_we)
		begin
			mem[i_addr[7:0]] <= i_wdata;
			o_writes <= o_writes + 1;
		end
		if (i_re)
		begin
			if (o_reads == 0)
			begin
				o_first_sel <= i_sel;
			end
			o_reads <= o_reads + 1;
		end
	end
endmodule : stack_mem_model

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic ref_clk = 1'b0; // cpu clock
	logic rst_n = 1'b0; // reset, active low
	cpu_flags_pkg::flag_op_t op = cpu_flags_pkg::FL_NONE;
	logic [7:0] res = 8'h00; // alu result
	logic hc = 1'b0; // half carry in
	logic cy = 1'b0; // carry in
	logic [11:0] pl = 12'h000; // one bit per pulse input
	logic [7:0] sd = 8'h00; // shared write data
	logic [15:0] pc = 16'h1234; // context sources
	logic [7:0] xr = 8'h56;
	logic [7:0] ac = 8'h9a;
	logic [7:0] ctx [5] = '{8'h34, 8'h12, 8'h56, 8'h9a, 8'he5};
	wire logic [7:0] cf;
	wire logic [15:0] sp;
	wire logic we;
	wire logic re;
	wire logic [15:0] addr;
	wire logic [7:0] wd;
	wire logic [2:0] sel;
	wire logic busy;
	int writes;
	int reads;
	wire logic [2:0] fsel;
	int miscompares = 0;
	int samples_checked = 0;
	always #10 ref_clk = ~ref_clk;
	cpu_flags_sp dut_u (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_flag_op(op),
		.i_result(res), .i_half_carry(hc), .i_carry(cy), .i_set_carry_instr(pl[0]),
		.i_clear_carry_instr(pl[1]), .i_prio_wr(pl[2]), .i_prio_wdata(sd[1:0]),
		.i_irq_entry(pl[3]), .i_source_priority_registers(sd[1:0]), .i_cf_wr(pl[4]),
		.i_cf_wdata(sd), .i_push(pl[5]), .i_pop(pl[6]), .i_call(pl[7]), .i_ret(pl[8]),
		.i_return_from_interrupt_instr(pl[9]), .i_stack_pointer_reinit_instr(pl[10]), .i_sp_wr(pl[11]),
		.i_sp_wdata(sd), .i_pc(pc), .i_index_x(xr), .i_accum(ac), .o_condition_flags(cf),
		.o_stack_pointer(sp), .o_mem_we(we), .o_mem_re(re), .o_mem_addr(addr),
		.o_mem_wdata(wd), .o_restore_sel(sel), .o_busy(busy));
	stack_mem_model mem_u (.i_ref_clk(ref_clk), .i_we(we), .i_re(re), .i_addr(addr),
		.i_wdata(wd), .i_sel(sel), .o_writes(writes), .o_reads(reads), .o_first_sel(fsel));
	// compare and count
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task chf(input logic [7:0] e);
		chk({8'h00, cf}, {8'h00, e});
	endtask : chf
	// one pulse on input k with data d, then let it land
	task pulse(input int k, input logic [7:0] d);
		@(posedge ref_clk);
		pl[k] <= 1'b1;
		sd <= d;
		@(posedge ref_clk);
		pl[k] <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask : pulse
	task fop(input cpu_flags_pkg::flag_op_t o, input logic [7:0] r, input logic h,
		input logic c, input logic [7:0] e);
		@(posedge ref_clk);
		op <= o;
		res <= r;
		hc <= h;
		cy <= c;
		@(posedge ref_clk);
		op <= cpu_flags_pkg::FL_NONE;
		@(posedge ref_clk);
		#1;
		chf(e);
	endtask : fop
	// bounded wait for the sequencer to finish
	task wait_idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 20)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		if (busy !== 1'b0)
		begin
			miscompares++;
		end
		// the last strobe reaches the model one edge after busy drops
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : wait_idle
	task print_verdict;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task test_flags;
		chf(8'he8);
		chk(sp, 16'h01ff);
		fop(cpu_flags_pkg::FL_ADD, 8'h80, 1'b1, 1'b1, 8'hfd);
		fop(cpu_flags_pkg::FL_ADD, 8'h00, 1'b0, 1'b0, 8'hea);
		fop(cpu_flags_pkg::FL_BTJ, 8'h80, 1'b0, 1'b1, 8'heb);
		fop(cpu_flags_pkg::FL_SHIFT, 8'h01, 1'b0, 1'b0, 8'he8);
		fop(cpu_flags_pkg::FL_LOGIC, 8'h00, 1'b0, 1'b1, 8'hea);
		fop(cpu_flags_pkg::FL_ARITH, 8'hff, 1'b0, 1'b1, 8'hed);
		pulse(1, 8'h00);
		chf(8'hec);
		pulse(0, 8'h00);
		chf(8'hed);
		pulse(2, 8'h00);
		chf(8'hc5);
		pulse(2, 8'h03);
		chf(8'hed);
		$display("flags test done");
	endtask : test_flags
	task test_stack;
		pulse(3, 8'h02);
		chk({15'h0000, busy}, 16'h0001);
		wait_idle;
		chf(8'he5);
		chk(sp, 16'h01fa);
		for (int i = 0; i < 5; i++)
			chk({8'h00, mem_u.mem[8'hff - i]}, {8'h00, ctx[i]});
		chk(16'(writes), 16'h0005);
		pulse(7, 8'h00);
		wait_idle;
		chk(sp, 16'h01f8);
		chk({8'h00, mem_u.mem[8'hfa]}, 16'h0034);
		pulse(9, 8'h00);
		wait_idle;
		chk(sp, 16'h01fd);
		chk(16'(reads), 16'h0005);
		chk({13'h0, fsel}, 16'h0004);
		pulse(8, 8'h00);
		wait_idle;
		chk(sp, 16'h01ff);
		pulse(4, 8'h33);
		chf(8'h33);
		$display("stack test done");
	endtask : test_stack
	task test_wrap;
		pulse(11, 8'h00);
		chk(sp, 16'h0100);
		pulse(5, 8'h00);
		chk(sp, 16'h01ff);
		pulse(6, 8'h00);
		chk(sp, 16'h0100);
		pulse(6, 8'h00);
		chk(sp, 16'h0101);
		pulse(10, 8'h00);
		chk(sp, 16'h01ff);
		$display("wrap test done");
	endtask : test_wrap
	initial
	begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		#1;
		test_flags;
		test_stack;
		test_wrap;
		print_verdict;
	end
	// watchdog
	initial
	begin
		#200000;
		miscompares++;
		print_verdict;
	end
endmodule : tb_top

/* File: hdl/cpu_flags_cfg.svh */
`ifndef CPU_FLAGS_CFG_SVH
`define CPU_FLAGS_CFG_SVH
// condition flag bit positions
`define CF_BIT_CARRY 0
`define CF_BIT_ZERO 1
`define CF_BIT_NEG 2
`define CF_BIT_PRIO_LOW 3
`define CF_BIT_HALF 4
`define CF_BIT_PRIO_HIGH 5
// reset values
`define CF_RESET 8'he8
`define SP_RESET 16'h01ff
`define SP_HIGH_FIXED 8'h01
`define SP_LOW_TOP 8'hff
// context sizes in bytes
`define CALL_BYTES 3'h2
`define IRQ_BYTES 3'h5
`endif

/* File: hdl/cpu_flags_pkg.sv */
package cpu_flags_pkg;
	// flag update kind requested by the sequencer
	typedef enum logic [2:0] {
		FL_NONE = 3'b000,
		FL_ADD = 3'b001,
		FL_LOGIC = 3'b010,
		FL_ARITH = 3'b011,
		FL_SHIFT = 3'b100,
		FL_BTJ = 3'b101
	} flag_op_t;
	// stack sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAVE = 2'b01,
		ST_RESTORE = 2'b10
	} stack_state_t;
endpackage : cpu_flags_pkg

/* File: hdl/cpu_flags_sp.sv */
`timescale 1ns/1ps
`include "cpu_flags_cfg.svh"
// Overview of operation
// - add sets half flag on bit-3 carry
// - add without bit-3 carry clears half flag
// - negative flag copies result bit 7
// - zero flag set when result is zero
// - carry from arithmetic; set/clear instructions write it
// - bit-test, shift, rotate also update carry
// - priority bits 5,3 encode software level
// - interrupt entry loads source priority
// - priority writable by listed instructions
// - whole register pushable; reset reads 111x1xxx
// - pointer decrements after push, increments before pop
// - stack 256 bytes, high byte fixed
// - reset or reinit sets pointer to 01ff
// - low pointer byte loadable and readable
// - pointer wraps silently both ways
// - interrupt saves program counter low first
// - call uses two bytes, interrupt five
// - return pops context in reverse order
// - second index register never saved
module cpu_flags_sp
(
	input wire logic i_ref_clk, // cpu clock
	input wire logic i_rst_n, // async reset, active low
	input wire cpu_flags_pkg::flag_op_t i_flag_op, // flag update kind
	input wire logic [7:0] i_result, // alu result
	input wire logic i_half_carry, // carry out of alu bit 3
	input wire logic i_carry, // carry or borrow of operation
	input wire logic i_set_carry_instr, // set carry instruction
	input wire logic i_clear_carry_instr, // clear carry instruction
	input wire logic i_prio_wr, // software priority write
	input wire logic [1:0] i_prio_wdata, // {high, low}
	input wire logic i_irq_entry, // interrupt entry pulse
	input wire logic [1:0] i_source_priority_registers, // level of source
	input wire logic i_cf_wr, // whole-register write (pop)
	input wire logic [7:0] i_cf_wdata, // data for whole write
	input wire logic i_push, // single-byte push
	input wire logic i_pop, // single-byte pop
	input wire logic i_call, // subroutine call push
	input wire logic i_ret, // subroutine return pop
	input wire logic i_return_from_interrupt_instr, // return from interrupt
	input wire logic i_stack_pointer_reinit_instr, // reinit pointer
	input wire logic i_sp_wr, // load instruction to low byte
	input wire logic [7:0] i_sp_wdata, // load data
	input wire logic [15:0] i_pc, // program counter for save
	input wire logic [7:0] i_index_x, // index register for save
	input wire logic [7:0] i_accum, // accumulator for save
	output logic [7:0] o_condition_flags, // condition register
	output logic [15:0] o_stack_pointer, // stack pointer
	output logic o_mem_we, // stack write strobe
	output logic o_mem_re, // stack read strobe
	output logic [15:0] o_mem_addr, // stack byte address
	output logic [7:0] o_mem_wdata, // stack write data
	output logic [2:0] o_restore_sel, // which context byte is read
	output logic o_busy // save or restore in progress
);
	// registers
	logic [7:0] cf_q; // condition flags
	logic [7:0] cf_d;
	logic [7:0] sp_low_q; // stack pointer low byte
	logic [7:0] sp_low_d;
	cpu_flags_pkg::stack_state_t st_q; // context sequencer state
	cpu_flags_pkg::stack_state_t st_d;
	logic [2:0] cnt_q; // bytes done in sequence
	logic [2:0] cnt_d;
	logic [2:0] len_q; // sequence length
	logic [2:0] len_d;
	logic [7:0] wdata_q; // registered push data
	logic [7:0] wdata_d;
	logic we_q; // registered write strobe
	logic re_q; // registered read strobe
	logic [15:0] addr_q; // registered address
	logic [2:0] sel_q; // registered restore index

	// wrapping pointer steps within the fixed page
	function automatic logic [7:0] sp_step(input logic [7:0] s, input logic up);
		sp_step = up ? s + 8'h01 : s - 8'h01;
	endfunction : sp_step

	// decoded events
	wire idle = (st_q == cpu_flags_pkg::ST_IDLE);
	wire start_irq = idle && i_irq_entry;
	wire start_call = idle && !i_irq_entry && i_call;
	wire start_return_from_interrupt_instr = idle && !i_irq_entry && !i_call && i_return_from_interrupt_instr;
	wire start_ret = idle && !i_irq_entry && !i_call && !i_return_from_interrupt_instr && i_ret;
	wire single_push = idle && !i_irq_entry && !i_call && !i_return_from_interrupt_instr && !i_ret && i_push;
	wire single_pop = idle && !i_irq_entry && !i_call && !i_return_from_interrupt_instr && !i_ret && !i_push
		&& i_pop;
	wire saving = (st_q == cpu_flags_pkg::ST_SAVE);
	wire restoring = (st_q == cpu_flags_pkg::ST_RESTORE);
	wire seq_last = (cnt_q == len_q - 3'h1);
	wire upd_nz = (i_flag_op != cpu_flags_pkg::FL_NONE) && (i_flag_op != cpu_flags_pkg::FL_BTJ);
	wire upd_c = (i_flag_op == cpu_flags_pkg::FL_ADD) || (i_flag_op == cpu_flags_pkg::FL_ARITH)
		|| (i_flag_op == cpu_flags_pkg::FL_SHIFT) || (i_flag_op == cpu_flags_pkg::FL_BTJ);

	// context byte chosen by count: pcl, pch, x, a, flags
	wire [7:0] save_byte = (cnt_q == 3'h0) ? i_pc[7:0] :
		(cnt_q == 3'h1) ? i_pc[15:8] :
		(cnt_q == 3'h2) ? i_index_x :
		(cnt_q == 3'h3) ? i_accum : cf_q;

	// flag next-value logic
	always_comb
	begin
		cf_d = cf_q;
		// half carry only on add kinds
		if (i_flag_op == cpu_flags_pkg::FL_ADD)
		begin
			cf_d[`CF_BIT_HALF] = i_half_carry;
		end
		// sign and zero from result
		if (upd_nz)
		begin
			cf_d[`CF_BIT_NEG] = i_result[7];
			cf_d[`CF_BIT_ZERO] = (i_result == 8'h00);
		end
		// carry from operation
		if (upd_c)
		begin
			cf_d[`CF_BIT_CARRY] = i_carry;
		end
		// dedicated carry instructions
		if (i_set_carry_instr)
		begin
			cf_d[`CF_BIT_CARRY] = 1'b1;
		end
		else if (i_clear_carry_instr)
		begin
			cf_d[`CF_BIT_CARRY] = 1'b0;
		end
		// software priority write
		if (i_prio_wr)
		begin
			cf_d[`CF_BIT_PRIO_HIGH] = i_prio_wdata[1];
			cf_d[`CF_BIT_PRIO_LOW] = i_prio_wdata[0];
		end
		// whole register restore
		if (i_cf_wr)
		begin
			cf_d = i_cf_wdata;
		end
		// interrupt entry priority load wins
		if (start_irq)
		begin
			cf_d[`CF_BIT_PRIO_HIGH] = i_source_priority_registers[1];
			cf_d[`CF_BIT_PRIO_LOW] = i_source_priority_registers[0];
		end
	end

	// stack pointer and sequencer next-value logic
	always_comb
	begin
		sp_low_d = sp_low_q;
		st_d = st_q;
		cnt_d = cnt_q;
		len_d = len_q;
		wdata_d = save_byte;
		// start of a multi-byte sequence
		if (start_irq || start_call)
		begin
			st_d = cpu_flags_pkg::ST_SAVE;
			cnt_d = 3'h0;
			len_d = start_irq ? `IRQ_BYTES : `CALL_BYTES;
		end
		else if (start_return_from_interrupt_instr || start_ret)
		begin
			st_d = cpu_flags_pkg::ST_RESTORE;
			cnt_d = 3'h0;
			len_d = start_return_from_interrupt_instr ? `IRQ_BYTES : `CALL_BYTES;
			sp_low_d = sp_step(sp_low_q, 1'b1);
		end
		else if (single_push)
		begin
			sp_low_d = sp_step(sp_low_q, 1'b0);
		end
		else if (single_pop)
		begin
			sp_low_d = sp_step(sp_low_q, 1'b1);
		end
		else if (saving)
		begin
			// write at pointer, then decrement
			sp_low_d = sp_step(sp_low_q, 1'b0);
			cnt_d = cnt_q + 3'h1;
			if (seq_last)
			begin
				st_d = cpu_flags_pkg::ST_IDLE;
			end
		end
		else if (restoring)
		begin
			// read pointed byte, pre-increment for the next one
			cnt_d = cnt_q + 3'h1;
			if (seq_last)
			begin
				st_d = cpu_flags_pkg::ST_IDLE;
			end
			else
			begin
				sp_low_d = sp_step(sp_low_q, 1'b1);
			end
		end
		// direct load or reinit overrides
		if (i_sp_wr && idle)
		begin
			sp_low_d = i_sp_wdata;
		end
		if (i_stack_pointer_reinit_instr && idle)
		begin
			sp_low_d = `SP_LOW_TOP;
		end
	end

	// state registers
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cf_q <= `CF_RESET;
			sp_low_q <= `SP_LOW_TOP;
			st_q <= cpu_flags_pkg::ST_IDLE;
			cnt_q <= 3'h0;
			len_q <= 3'h0;
		end
		else
		begin
			cf_q <= cf_d;
			sp_low_q <= sp_low_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			len_q <= len_d;
		end
	end

	// registered memory strobes
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			we_q <= 1'b0;
			re_q <= 1'b0;
			addr_q <= `SP_RESET;
			wdata_q <= 8'h00;
			sel_q <= 3'h0;
		end
		else
		begin
			we_q <= saving;
			re_q <= restoring;
			addr_q <= {`SP_HIGH_FIXED, sp_low_q};
			wdata_q <= wdata_d;
			sel_q <= len_q - 3'h1 - cnt_q; // reverse order
		end
	end

	// outputs
	assign o_condition_flags = cf_q;
	assign o_stack_pointer = {`SP_HIGH_FIXED, sp_low_q};
	assign o_mem_we = we_q;
	assign o_mem_re = re_q;
	assign o_mem_addr = addr_q;
	assign o_mem_wdata = wdata_q;
	assign o_restore_sel = sel_q;
	assign o_busy = !idle;

	// checks
	property p_half;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_flag_op == cpu_flags_pkg::FL_ADD && !i_cf_wr) |=> (cf_q[4] == $past(i_half_carry));
	endproperty
	a_half: assert property (p_half) else $error("half flag wrong");
	property p_zero;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(upd_nz && !i_cf_wr) |=> (cf_q[1] == ($past(i_result) == 8'h00));
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_neg;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(upd_nz && !i_cf_wr) |=> (cf_q[2] == $past(i_result[7]));
	endproperty
	a_neg: assert property (p_neg) else $error("negative flag wrong");
	property p_scf;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_set_carry_instr && !i_cf_wr) |=> cf_q[0];
	endproperty
	a_scf: assert property (p_scf) else $error("carry not set");
	property p_prio;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		start_irq |=> ({cf_q[5], cf_q[3]} == $past(i_source_priority_registers));
	endproperty
	a_prio: assert property (p_prio) else $error("priority not loaded");
	property p_high;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_stack_pointer[15:8] == 8'h01;
	endproperty
	a_high: assert property (p_high) else $error("pointer page moved");
	sequence s_irq_save;
		o_mem_we [*5];
	endsequence
	property p_irq5;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		start_irq |-> ##2 s_irq_save ##1 !o_mem_we;
	endproperty
	a_irq5: assert property (p_irq5) else $error("interrupt save not five");
	property p_pcl;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		start_irq |-> ##2 (o_mem_wdata == $past(i_pc[7:0], 1)
			&& o_mem_addr == $past(o_stack_pointer, 2));
	endproperty
	a_pcl: assert property (p_pcl) else $error("pcl not first");
	property p_push;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(single_push && !i_sp_wr && !i_stack_pointer_reinit_instr)
		|=> (sp_low_q == $past(sp_low_q) - 8'h01);
	endproperty
	a_push: assert property (p_push) else $error("push did not decrement");
	// pop pre-increments the low byte and wraps at the page top
	property p_pop;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(single_pop && !i_sp_wr && !i_stack_pointer_reinit_instr)
		|=> (sp_low_q == $past(sp_low_q) + 8'h01);
	endproperty
	a_pop: assert property (p_pop) else $error("pop did not increment");
	// clear carry instruction alone leaves carry low
	property p_rcf;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clear_carry_instr && !i_set_carry_instr && !i_cf_wr) |=> !cf_q[0];
	endproperty
	a_rcf: assert property (p_rcf) else $error("carry not cleared");
	// reinit puts the pointer back at the stack top
	property p_reinit;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_stack_pointer_reinit_instr && idle) |=> (sp_low_q == `SP_LOW_TOP);
	endproperty
	a_reinit: assert property (p_reinit) else $error("pointer not reinitialised");
	// direct load of the low byte while idle
	property p_load;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_sp_wr && idle && !i_stack_pointer_reinit_instr) |=> (sp_low_q == $past(i_sp_wdata));
	endproperty
	a_load: assert property (p_load) else $error("pointer load lost");
	// call writes exactly two return address bytes
	sequence s_call_save;
		o_mem_we [*2];
	endsequence
	property p_call2;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		start_call |-> ##2 s_call_save ##1 !o_mem_we;
	endproperty
	a_call2: assert property (p_call2) else $error("call save not two");
	// interrupt return reads the flags byte first
	property p_restore;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		start_return_from_interrupt_instr |-> ##2 (o_mem_re && o_restore_sel == 3'h4);
	endproperty
	a_restore: assert property (p_restore) else $error("restore order wrong");
endmodule : cpu_flags_sp
